// ===== test/sefd_link_ctrl.sv
// Behavioural remote controller on the four-wire link: mode 0, MSB first.
// Assumes one caller at a time; its timing is its own and unrelated to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module sefd_link_ctrl
    import sefd_pkg::*;
(
    output var sefd_pins_type pins,
    input  wire logic         miso
);
    initial pins = 3'b010;

    // The odd lead-in keeps pin changes away from the sampling clock edges.
    task automatic select(input logic on);
        #37 pins.sel_n = ~on;
        pins.mosi = ~pins.mosi;
        #200;
    endtask : select

    // The clock stands low between words, and the released data line toggles
    // so that a stale bit can never pass for a fresh one.
    task automatic xfer(input int n, input logic [15:0] d);
        for (int i = n - 1; i >= 0; i--)
        begin
            pins.mosi = d[i];
            #200 pins.sclk = 1'b1;
            #200 pins.sclk = 1'b0;
        end
        pins.mosi = ~pins.mosi;
    endtask : xfer
endmodule : sefd_link_ctrl
`default_nettype wire

// ===== test/sefd_top_tb.sv
// Self-checking bench of sefd_top: APB master, link controller model, integer flag model.
// Assumes sefd_pkg compiled first and sefd_regs.svh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "sefd_regs.svh"
module sefd_top_tb
    import sefd_pkg::*;
;
    localparam logic [11:0] A_MSK = `SEFD_OFS_IRQ_MASK;
    localparam logic [11:0] A_CFG = `SEFD_OFS_CONFIG;
    localparam logic [11:0] A_FLG = `SEFD_OFS_EVENT_FLAG;
    localparam logic [11:0] A_CLR = `SEFD_OFS_FLAG_CLEAR;
    localparam logic [11:0] A_DAT = `SEFD_OFS_DATA;
    logic          ref_clk = 1'b0;
    logic          arst_n  = 1'b0;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [11:0]   paddr   = 12'h000;
    logic [31:0]   pwdata  = 32'h0000_0000;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    sefd_pins_type link_pins;
    logic          miso;
    logic          irq;
    logic [31:0]   q;
    logic          slverr;
    logic [15:0]   w;
    int            err_count = 0;
    int            checked   = 0;
    int            ef        = 1;
    int            msk       = 0;

    always #25 ref_clk = ~ref_clk;

    sefd_top #(.DATA_WIDTH(16)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_pins(link_pins), .miso(miso), .irq(irq));
    sefd_link_ctrl u_link (.pins(link_pins), .miso(miso));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Entered just after a rising edge; read data is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wr ? d : 32'($urandom);
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            err_count++;
            wrap_up();
        end
        slverr = pslverr;
        q      = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic flags(input logic lvl);
        apb(1'b0, A_FLG, 32'h0);
        chk("event_flag_reg", {22'h0, lvl, 1'b0, ef[7:0]}, q);
        chk("irq", {31'h0, (ef[7:0] & msk[7:0]) != 8'h00}, {31'h0, irq});
    endtask : flags

    // Each of flags 7..1 is cleared on its own so that a wrong bit position shows at once.
    task automatic clr_all(input logic lvl);
        for (int b = 7; b >= 1; b--)
        begin
            apb(1'b1, A_CLR, {24'h0, ~(8'h01 << b)});
            ef = ef & ~(1 << b);
            flags(lvl);
        end
    endtask : clr_all

    task automatic frame(input int n, input int words);
        u_link.select(1'b1);
        repeat (words)
        begin
            w = 16'($urandom);
            u_link.xfer(n, w);
        end
        u_link.select(1'b0);
        repeat (8) @(posedge ref_clk);
    endtask : frame

    initial
    begin
        void'($urandom(92903));
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        flags(1'b1);
        apb(1'b0, A_MSK, 32'h0);
        chk("irq_mask_reg", 32'h0, q);
        apb(1'b0, A_CLR, 32'h0);
        chk("flag_clear_reg", 32'hFF, q);
        apb(1'b0, A_DAT, 32'h0);
        chk("data_window_reg", 32'h0, q);
        msk = $urandom & 8'hFF;
        apb(1'b1, A_MSK, 32'(msk));
        apb(1'b0, A_MSK, 32'h0);
        chk("irq_mask_reg", 32'(msk), q);
        flags(1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, {31'h0, slverr});
        msk = 0;
        apb(1'b1, A_MSK, 32'h0);
        fork
            frame(16, 1);
            begin
                repeat (20) @(posedge ref_clk);
                apb(1'b0, A_FLG, 32'h0);
                chk("busy_level", 32'h1, {30'h0, q[9:8]});
            end
        join
        ef = ef | 8'h1E;
        flags(1'b1);
        apb(1'b0, A_DAT, 32'h0);
        chk("data_window_reg", {16'h0, w}, q);
        ef = ef & ~2;
        flags(1'b1);
        clr_all(1'b1);
        apb(1'b1, A_DAT, 32'(16'($urandom)));
        ef = 0;
        flags(1'b1);
        frame(16, 2);
        ef = 8'h3F;
        flags(1'b1);
        apb(1'b0, A_DAT, 32'h0);
        chk("data_window_reg", {16'h0, w}, q);
        ef = ef & ~2;
        clr_all(1'b1);
        apb(1'b1, A_DAT, 32'(16'($urandom)));
        ef = 0;
        flags(1'b1);
        apb(1'b1, A_CLR, 32'hFE);
        ef = 1;
        flags(1'b1);
        msk = 8'h08;
        apb(1'b1, A_MSK, 32'h08);
        flags(1'b1);
        u_link.select(1'b1);
        u_link.select(1'b0);
        repeat (8) @(posedge ref_clk);
        ef = 8'h0D;
        flags(1'b1);
        clr_all(1'b1);
        u_link.select(1'b1);
        u_link.xfer(5, 16'($urandom));
        u_link.select(1'b0);
        repeat (8) @(posedge ref_clk);
        ef = 8'h4D;
        flags(1'b1);
        clr_all(1'b1);
        apb(1'b1, A_CFG, 32'h07);
        frame(8, 1);
        apb(1'b0, A_DAT, 32'h0);
        chk("data_window_reg", {24'h0, w[7:0]}, q);
        ef = 8'h1D;
        flags(1'b1);
        clr_all(1'b1);
        apb(1'b1, A_CFG, 32'h17);
        u_link.select(1'b1);
        repeat (8) @(posedge ref_clk);
        ef = 8'h85;
        flags(1'b0);
        u_link.select(1'b0);
        repeat (8) @(posedge ref_clk);
        ef = 8'h8D;
        flags(1'b1);
        clr_all(1'b1);
        wrap_up();
    end
endmodule : sefd_top_tb
`default_nettype wire

// ===== verilog/sefd_pkg.sv
// Types shared by the serial port flag block.
// Assumes sefd_regs.svh on the include path.
`include "sefd_regs.svh"
package sefd_pkg;
    typedef enum logic [1:0] {
        SEFD_IDLE  = 2'b00,
        SEFD_SHIFT = 2'b01,
        SEFD_DONE  = 2'b11
    } sefd_link_state_type;

    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic mosi;
    } sefd_pins_type;

    typedef struct packed {
        logic [2:0]          sclk_sync;
        logic [2:0]          sel_sync;
        logic [2:0]          mosi_sync;
        logic                sclk_stable;
        logic                sel_stable;
        logic                mosi_stable;
        sefd_link_state_type link_state;
        logic [4:0]          bit_count;
        logic [15:0]         shift_in;
        logic [15:0]         shift_out;
        logic                shift_loaded;
        logic [15:0]         tx_word;
        logic                tx_full;
        logic [15:0]         rx_word;
        logic [7:0]          flags;
        logic [7:0]          irq_mask;
        logic [4:0]          config_bits;
        logic [31:0]         prdata;
        logic                rd_wait;
        logic                miso;
    } sefd_state_type;
endpackage : sefd_pkg

// ===== verilog/sefd_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial port flag block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SEFD_REGS_SVH
`define SEFD_REGS_SVH
`define SEFD_OFS_IRQ_MASK   12'h004
`define SEFD_OFS_CONFIG     12'h008
`define SEFD_OFS_EVENT_FLAG 12'h010
`define SEFD_OFS_FLAG_CLEAR 12'h014
`define SEFD_OFS_DATA       12'h018
`define SEFD_BIT_CONFLICT   7
`define SEFD_BIT_SEL_FAULT  6
`define SEFD_BIT_RX_LOST    5
`define SEFD_BIT_TX_STARVED 4
`define SEFD_BIT_SEL_RISE   3
`define SEFD_BIT_SEL_FALL   2
`define SEFD_BIT_RX_FULL    1
`define SEFD_BIT_TX_VACANT  0
`define SEFD_BIT_BUSY       8
`define SEFD_BIT_SEL_LEVEL  9
`define SEFD_BIT_ROLE       4
`define SEFD_CFG_WIDTH_MSB  3
`define SEFD_RST_IRQ_MASK   8'h00
`define SEFD_RST_FLAGS      8'h01
`define SEFD_RST_CLEAR      32'h0000_00FF
`define SEFD_RST_CONFIG     5'h0F
`define SEFD_SYNC_STAGES    3
`endif

// ===== verilog/sefd_top.sv
// Serial port event flags, interrupt mask, flag clear and data window behind an APB slave.
// Assumes a 20 MHz ref_clk and link pins from outside its domain, sampled through three flip-flops.
// Summary of operation
// - Eight interrupt enable bits, one per event, zero disables, one enables.
// - In controller role a low select input sets master_conflict_err, bit 7.
// - In target role a select error sets sel_fault_err, bit 6.
// - A word received while the receive buffer is unread sets rx_lost_word_err.
// - In target role, a clock fall at bit count zero with the shifter unloaded sets tx_starved_err.
// - Select rising edge sets bit 3, falling edge sets bit 2.
// - rx_full_flag is one while data waits; data read or clear write clears it.
// - tx_vacant_flag is one when the transmit buffer is empty.
// - After reset the flag register reads the transmit-empty bit and the select level bit 9 set.
// - Bit 9 shows the present select level.
// - Bit 8 reads one while a transfer is in progress.
// - Writing zero to clear bits 7..1 clears that flag; clear register reads ones.
// - Writing zero to tx_purge empties transmit buffer and shifter, sets tx_vacant_flag.
// - Data register low half writes a word to send and reads the last received.
// - Valid bits per word equal frame width field plus one, up to sixteen.
// - controller_role zero selects target role, one selects controller role.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "sefd_regs.svh"
module sefd_top
    import sefd_pkg::*;
#(
    parameter int DATA_WIDTH = 16
)(
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire sefd_pins_type link_pins,
    output logic               miso,
    output logic               irq
);
    logic [1:0]     rst_sync;
    logic           rst_n;
    sefd_state_type cur;
    sefd_state_type next_state;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    logic        wr_acc;
    logic        rd_req;
    logic        rd_acc;
    logic        hit_mask;
    logic        hit_cfg;
    logic        hit_flag;
    logic        hit_clear;
    logic        hit_data;
    logic        mapped;
    logic        role_ctrl;
    logic [4:0]  last_bit;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sel_rise;
    logic        sel_fall;
    logic        word_done;
    logic        starve;
    logic        sel_error;
    logic [7:0]  set_ev;
    logic [7:0]  clr_ev;
    logic [31:0] rd_value;

    assign hit_mask  = (paddr == `SEFD_OFS_IRQ_MASK);
    assign hit_cfg   = (paddr == `SEFD_OFS_CONFIG);
    assign hit_flag  = (paddr == `SEFD_OFS_EVENT_FLAG);
    assign hit_clear = (paddr == `SEFD_OFS_FLAG_CLEAR);
    assign hit_data  = (paddr == `SEFD_OFS_DATA);
    assign mapped    = hit_mask | hit_cfg | hit_flag | hit_clear | hit_data;
    assign wr_acc    = psel & penable & pwrite & mapped;
    // A read waits one cycle so that the registered read data stands at the edge that completes it.
    assign rd_req    = psel & penable & ~pwrite;
    assign rd_acc    = rd_req & mapped & cur.rd_wait;
    assign pready    = ~rd_req | cur.rd_wait;
    assign pslverr   = psel & penable & ~mapped;
    assign role_ctrl = cur.config_bits[`SEFD_BIT_ROLE];
    assign last_bit  = {1'b0, cur.config_bits[`SEFD_CFG_WIDTH_MSB:0]};

    // A pin level counts as changed only when the second and third stages agree.
    assign sclk_rise = (cur.sclk_sync[1] == cur.sclk_sync[2]) & cur.sclk_sync[2] & ~cur.sclk_stable;
    assign sclk_fall = (cur.sclk_sync[1] == cur.sclk_sync[2]) & ~cur.sclk_sync[2] & cur.sclk_stable;
    assign sel_rise  = (cur.sel_sync[1] == cur.sel_sync[2]) & cur.sel_sync[2] & ~cur.sel_stable;
    assign sel_fall  = (cur.sel_sync[1] == cur.sel_sync[2]) & ~cur.sel_sync[2] & cur.sel_stable;
    assign word_done = ~role_ctrl & sclk_rise & ~cur.sel_stable & (cur.bit_count == last_bit);
    // A target that is clocked with nothing loaded shifts out stale data.
    assign starve    = ~role_ctrl & sclk_fall & ~cur.sel_stable & ~cur.shift_loaded
                       & (cur.bit_count == 5'd0);
    // Select released in the middle of a word is a select error for a target.
    assign sel_error = ~role_ctrl & sel_rise & (cur.link_state == SEFD_SHIFT) & (cur.bit_count != 5'd0);

    always_comb
    begin
        set_ev = 8'h00;
        set_ev[`SEFD_BIT_CONFLICT]   = role_ctrl & ~cur.sel_stable;
        set_ev[`SEFD_BIT_SEL_FAULT]  = sel_error;
        set_ev[`SEFD_BIT_RX_LOST]    = word_done & cur.flags[`SEFD_BIT_RX_FULL];
        set_ev[`SEFD_BIT_TX_STARVED] = starve;
        set_ev[`SEFD_BIT_SEL_RISE]   = sel_rise;
        set_ev[`SEFD_BIT_SEL_FALL]   = sel_fall;
        set_ev[`SEFD_BIT_RX_FULL]    = word_done;
        clr_ev = 8'h00;
        if (wr_acc && hit_clear)
            clr_ev[7:1] = ~pwdata[7:1];
        if (rd_acc && hit_data)
            clr_ev[`SEFD_BIT_RX_FULL] = 1'b1;
    end

    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (hit_mask)
            rd_value = {24'h00_0000, cur.irq_mask};
        else if (hit_cfg)
            rd_value = {27'h000_0000, cur.config_bits};
        else if (hit_flag)
            rd_value = {22'h00_0000, cur.sel_stable, cur.link_state != SEFD_IDLE, cur.flags};
        else if (hit_clear)
            rd_value = `SEFD_RST_CLEAR;
        else if (hit_data)
            rd_value = {16'h0000, cur.rx_word};
    end

    always_comb
    begin
        next_state = cur;
        next_state.sclk_sync = {cur.sclk_sync[1:0], link_pins.sclk};
        next_state.sel_sync  = {cur.sel_sync[1:0], link_pins.sel_n};
        next_state.mosi_sync = {cur.mosi_sync[1:0], link_pins.mosi};
        if (cur.sclk_sync[1] == cur.sclk_sync[2])
            next_state.sclk_stable = cur.sclk_sync[2];
        if (cur.sel_sync[1] == cur.sel_sync[2])
            next_state.sel_stable = cur.sel_sync[2];
        if (cur.mosi_sync[1] == cur.mosi_sync[2])
            next_state.mosi_stable = cur.mosi_sync[2];
        next_state.prdata  = (rd_req && mapped && !cur.rd_wait) ? rd_value : cur.prdata;
        next_state.rd_wait = rd_req & ~cur.rd_wait;

        if (wr_acc && hit_mask)
            next_state.irq_mask = pwdata[7:0];
        if (wr_acc && hit_cfg)
            next_state.config_bits = pwdata[4:0];

        // Shift engine: target role, mode 0, MSB first within the configured width.
        case (cur.link_state)
            SEFD_IDLE:
            begin
                next_state.bit_count = 5'd0;
                if (!role_ctrl && !cur.sel_stable)
                    next_state.link_state = SEFD_SHIFT;
            end
            SEFD_SHIFT:
            begin
                if (cur.sel_stable || role_ctrl)
                    next_state.link_state = SEFD_IDLE;
                else if (sclk_rise)
                begin
                    next_state.shift_in  = {cur.shift_in[14:0], cur.mosi_stable};
                    next_state.bit_count = cur.bit_count + 5'd1;
                    if (word_done)
                        next_state.link_state = SEFD_DONE;
                end
                if (sclk_fall && cur.bit_count == 5'd0 && cur.tx_full)
                begin
                    next_state.shift_out    = cur.tx_word << (5'd15 - last_bit);
                    next_state.shift_loaded = 1'b1;
                    next_state.tx_full      = 1'b0;
                end
                else if (sclk_fall && cur.bit_count != 5'd0)
                    next_state.shift_out = {cur.shift_out[14:0], 1'b0};
            end
            SEFD_DONE:
            begin
                next_state.rx_word      = cur.shift_in & ((16'h0001 << (last_bit + 5'd1)) - 16'h0001);
                next_state.shift_loaded = 1'b0;
                next_state.bit_count    = 5'd0;
                next_state.link_state   = cur.sel_stable ? SEFD_IDLE : SEFD_SHIFT;
            end
            default:
                next_state.link_state = SEFD_IDLE;
        endcase
        next_state.miso = cur.shift_out[15];

        if (wr_acc && hit_data)
        begin
            next_state.tx_word = pwdata[15:0];
            next_state.tx_full = 1'b1;
        end
        if (wr_acc && hit_clear && !pwdata[`SEFD_BIT_TX_VACANT])
        begin
            next_state.tx_full      = 1'b0;
            next_state.shift_out    = 16'h0000;
            next_state.shift_loaded = 1'b0;
        end

        next_state.flags[7:1] = (cur.flags[7:1] & ~clr_ev[7:1]) | set_ev[7:1];
        next_state.flags[`SEFD_BIT_TX_VACANT] = ~next_state.tx_full;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur             <= '0;
            cur.sclk_sync   <= 3'b000;
            cur.sel_sync    <= 3'b111;
            cur.sel_stable  <= 1'b1;
            cur.link_state  <= SEFD_IDLE;
            cur.flags       <= `SEFD_RST_FLAGS;
            cur.irq_mask    <= `SEFD_RST_IRQ_MASK;
            cur.config_bits <= `SEFD_RST_CONFIG;
        end
        else
            cur <= next_state;
    end

    assign prdata = cur.prdata;
    assign miso   = cur.miso;
    assign irq    = |(cur.flags & cur.irq_mask);

    chk_flag_reset_value: assert property (@(posedge ref_clk) $rose(rst_n) |-> cur.flags == 8'h01)
        else $error("flag register not at reset value");
    chk_irq_level_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq == |(cur.flags & cur.irq_mask))
        else $error("interrupt output disagrees with flags and mask");
    chk_clear_zero_works: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_acc && hit_clear && !pwdata[5] && !set_ev[5] |=> !cur.flags[5])
        else $error("write zero did not clear overflow flag");
    chk_set_beats_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        set_ev[3] |=> cur.flags[3])
        else $error("rising edge event lost");
    chk_purge_sets_vacant: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_acc && hit_clear && !pwdata[0] |=> cur.flags[0])
        else $error("purge did not set transmit empty");
    chk_vacant_tracks_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cur.flags[0] == !cur.tx_full)
        else $error("transmit empty flag wrong");
    chk_conflict_in_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_n)
        role_ctrl && !cur.sel_stable |=> cur.flags[7])
        else $error("controller conflict not flagged");
    chk_rx_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_acc && hit_data && !word_done |=> !cur.flags[1])
        else $error("data read did not clear receive flag");
    chk_overflow_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_done && cur.flags[1] |=> cur.flags[5])
        else $error("overflow not flagged");
    chk_clear_reads_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_acc && hit_clear |=> prdata == 32'h0000_00FF)
        else $error("clear register readback wrong");
    chk_target_no_conflict: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !role_ctrl && !cur.flags[7] && !(wr_acc && hit_cfg) |=> !cur.flags[7])
        else $error("conflict flag raised in target role");

    cov_word_received: cover property (@(posedge ref_clk) disable iff (!rst_n) word_done);
    cov_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n) set_ev[5]);
    cov_irq_raised: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
    cov_starve: cover property (@(posedge ref_clk) disable iff (!rst_n) starve);
endmodule : sefd_top
`default_nettype wire
